// ===== ulms_status.sv
// Line status, modem status, scratchpad and enhanced mode logic of a UART.
// Behaviour
// - Overrun sets flag, drops byte, FIFO intact.
// - Parity error tag follows head character.
// - Framing error tag follows head character.
// - Break loads one character, held until high.
// - Holding-empty flag tracks transmit FIFO emptiness.
// - Idle flag when FIFO, stage and shifter empty.
// - FIFO error flag ORs all stored tags.
// - CTS, DSR, CD changes set delta bits.
// - Ring delta only on ring input rising.
// - Any delta raises enabled modem interrupt.
// - Auto CTS high halts after current character.
// - Upper bits show inverted modem inputs.
// - Loopback maps modem control bits upward.
// - Extra control bits 4,5 disable transmitter, receiver.
// - Bit 6 selects 9-bit multidrop mode.
// - Bit 7 selects fast infrared pulse.
// - Scratchpad resets to all ones.
// - Swap routes scratchpad writes to mode register.
// - Alternating mode reads RX then TX level.
// - Send-immediately, with FIFO enabled, bypasses FIFO and self-clears once sent.
// - Direction mode drives RTS, optionally inverted.
// - Error interrupt delayed or immediate per bit.
`include "ulms_params.svh"
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Flip-flop FIFO with valid and ready on both sides.
// ----------------------------------------------------------------------
module ulms_fifo
  import ulms_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = 2,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Fill side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // Drain side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  // Level
  input  wire logic [CW-1:0] limit,
  output logic [CW-1:0]      count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] rd_q;
  logic [AW-1:0] wr_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_q < limit;
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rd_q];
  assign count     = cnt_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_entry
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          mem_q[gi] <= '0;
        else if (push && wr_q == AW'(gi))
          mem_q[gi] <= in_data;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_q  <= '0;
      wr_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule : ulms_fifo

// ----------------------------------------------------------------------
// Top of the status block.
// ----------------------------------------------------------------------
module ulms_status
  import ulms_pkg::*;
#(
  parameter int DEPTH = `ULMS_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST_N,
  // Host bus
  input  wire logic [2:0] A,
  input  wire logic       CS_N,
  input  wire logic       IOR_N,
  input  wire logic       IOW_N,
  input  wire logic [7:0] D_IN,
  output logic [7:0]      D_OUT,
  output logic            D_OE_N,
  // Settings held in neighbouring registers
  input  wire logic       DIV_SEL,
  input  wire logic       FIFO_EN,
  input  wire logic [7:0] MODEM_CTRL,
  input  wire logic       ENH_EN,
  input  wire logic       AUTO_CTS_EN,
  input  wire logic       SWAP_EN,
  input  wire logic       RS485_EN,
  input  wire logic       LSR_INT_EN,
  input  wire logic       MSR_INT_EN,
  // Receive deserializer
  input  wire logic       RX_VALID,
  input  wire logic [7:0] RX_DATA,
  input  wire logic       RX_PE,
  input  wire logic       RX_FE,
  input  wire logic       RX_BRK,
  input  wire logic       RX_LINE,
  // Transmit serializer
  output logic            TX_VALID,
  input  wire logic       TX_READY,
  output logic [7:0]      TX_DATA,
  input  wire logic       TX_BUSY,
  // Modem pins
  input  wire logic       CTS_N,
  input  wire logic       DSR_N,
  input  wire logic       RI_N,
  input  wire logic       CD_N,
  output logic            RTS_N,
  // Mode outputs and interrupt requests
  output logic            TX_DISABLE,
  output logic            RX_DISABLE,
  output logic            NINE_BIT,
  output logic            FAST_IR,
  output logic            LSR_INT,
  output logic            MSR_INT
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int SW = $clog2(`ULMS_STAGE_DEPTH + 1);

  logic           rd_act_q, wr_act_q, rd_start, wr_start, rd_act, wr_act;
  logic [7:0]     rdata_q;
  ulms_byte_t     spr_q, ems_q;
  logic [3:0]     xfc_q;
  logic           oe_q, brk_hold_q, lsr_imm_q, imm_sent_q;
  ulms_sel_e      alt_q;
  logic [3:0]     dlt_q, st_prev_q, st;
  logic [CW:0]    err_cnt_q;
  logic [CW-1:0]  rx_cnt, tx_cnt, lim;
  logic [10:0]    rx_head;
  logic           rx_pop, rx_push, rx_in_rdy, rx_nempty, rx_take;
  logic           tx_push, tx_in_rdy, tx_nempty, imm_wr;
  logic           st_in_v, st_in_r, st_out_v, fifo_out_v, flagged;
  logic [8:0]     st_in_d, st_out_d;
  logic [7:0]     tx_f_d, line_status, modem_input_status, fc;
  logic           rx_err_in, data_acc;

  // --------------------------------------------------------------------
  // Host bus strobes.
  // --------------------------------------------------------------------
  assign rd_act   = !CS_N && !IOR_N;
  assign wr_act   = !CS_N && !IOW_N;
  assign rd_start = rd_act && !rd_act_q;
  assign wr_start = wr_act && !wr_act_q;
  assign data_acc = A == `ULMS_OFF_DATA && !DIV_SEL;
  assign D_OUT    = rdata_q;
  assign D_OE_N   = !(rd_act && rd_act_q);

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end
    else
    begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
    end
  end

  // Counter source: x0 receive, 01 transmit, 11 alternating.
  always_comb
  begin
    fc = 8'(rx_cnt);
    if (ems_q[1:0] == 2'b01 || (ems_q[1:0] == 2'b11 && alt_q == ULMS_SEL_TX))
      fc = 8'(tx_cnt);
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rdata_q <= 8'h00;
    else if (rd_start)
      unique case (A)
        `ULMS_OFF_DATA: rdata_q <= DIV_SEL ? 8'h00 : rx_head[7:0];
        `ULMS_OFF_LSR:  rdata_q <= line_status;
        `ULMS_OFF_MSR:  rdata_q <= modem_input_status;
        `ULMS_OFF_SPR:  rdata_q <= SWAP_EN ? fc : spr_q;
        default:        rdata_q <= 8'h00;
      endcase
  end

  // --------------------------------------------------------------------
  // Scratchpad, extra function control and enhanced mode select.
  // --------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      spr_q <= `ULMS_SPR_RESET;
    else if (wr_start && A == `ULMS_OFF_SPR && !SWAP_EN)
      spr_q <= D_IN;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      xfc_q <= `ULMS_XFC_RESET;
    else if (wr_start && A == `ULMS_OFF_MSR && ENH_EN)
      xfc_q <= D_IN[7:4];
  end

  assign TX_DISABLE = xfc_q[`ULMS_XFC_TXDIS - 4];
  assign RX_DISABLE = xfc_q[`ULMS_XFC_RXDIS - 4];
  assign NINE_BIT   = xfc_q[`ULMS_XFC_NINE - 4];
  assign FAST_IR    = xfc_q[`ULMS_XFC_FIR - 4];

  // The immediate bit clears once its byte left the shifter; the host
  // setting it again in that very cycle wins.
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      ems_q <= `ULMS_EMS_RESET;
    else if (wr_start && A == `ULMS_OFF_SPR && SWAP_EN)
      ems_q <= D_IN;
    else if (imm_sent_q && !TX_BUSY && !st_out_v)
      ems_q[`ULMS_EMS_IMM] <= 1'b0;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      alt_q <= ULMS_SEL_RX;
    else if (wr_start && A == `ULMS_OFF_SPR && SWAP_EN)
      alt_q <= ULMS_SEL_RX;
    else if (rd_start && A == `ULMS_OFF_SPR && SWAP_EN &&
             ems_q[1:0] == 2'b11)
      alt_q <= (alt_q == ULMS_SEL_RX) ? ULMS_SEL_TX : ULMS_SEL_RX;
  end

  // --------------------------------------------------------------------
  // Receive FIFO with per-character error tags.
  // --------------------------------------------------------------------
  assign lim       = FIFO_EN ? CW'(DEPTH) : CW'(1);
  assign rx_take   = RX_VALID && !RX_DISABLE && !(RX_BRK && brk_hold_q);
  assign rx_push   = rx_take && rx_in_rdy;
  assign rx_pop    = rd_start && data_acc;
  assign rx_err_in = RX_PE || RX_FE || RX_BRK;

  ulms_fifo #(.W(11), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .in_valid  (rx_take),
    .in_ready  (rx_in_rdy),
    .in_data   ({RX_BRK, RX_FE, RX_PE, RX_DATA}),
    .out_valid (rx_nempty),
    .out_ready (rx_pop),
    .out_data  (rx_head),
    .limit     (lim),
    .count     (rx_cnt)
  );

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      oe_q <= 1'b0;
    else if (rx_take && !rx_in_rdy)
      oe_q <= 1'b1;
    else if (rd_start && A == `ULMS_OFF_LSR)
      oe_q <= 1'b0;
  end

  // A held break is released only by the line going back to mark.
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      brk_hold_q <= 1'b0;
    else if (RX_LINE)
      brk_hold_q <= 1'b0;
    else if (rx_push && RX_BRK)
      brk_hold_q <= 1'b1;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      err_cnt_q <= '0;
    else
      err_cnt_q <= err_cnt_q + (CW+1)'(rx_push && rx_err_in)
                   - (CW+1)'(rx_pop && rx_nempty && |rx_head[10:8]);
  end

  // Immediate error interrupt: set on entry, cleared by a status read.
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      lsr_imm_q <= 1'b0;
    else if (rx_push && rx_err_in)
      lsr_imm_q <= 1'b1;
    else if (rd_start && A == `ULMS_OFF_LSR)
      lsr_imm_q <= 1'b0;
  end

  // --------------------------------------------------------------------
  // Transmit FIFO and two-entry stage in front of the serializer.
  // --------------------------------------------------------------------
  assign imm_wr  = ems_q[`ULMS_EMS_IMM] && FIFO_EN;
  assign tx_push = wr_start && data_acc && !imm_wr;

  ulms_fifo #(.W(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .in_valid  (tx_push),
    .in_ready  (tx_in_rdy),
    .in_data   (D_IN),
    .out_valid (fifo_out_v),
    .out_ready (st_in_r && !(wr_start && data_acc && imm_wr)),
    .out_data  (tx_f_d),
    .limit     (lim),
    .count     (tx_cnt)
  );

  // Send-immediately writes skip the FIFO and take the stage first.
  always_comb
  begin
    st_in_v = fifo_out_v;
    st_in_d = {1'b0, tx_f_d};
    if (wr_start && data_acc && imm_wr)
    begin
      st_in_v = 1'b1;
      st_in_d = {1'b1, D_IN};
    end
  end

  // The serializer takes a character only between frames, so holding
  // TX_VALID low stops after the character in progress.
  assign flagged  = !(AUTO_CTS_EN && modem_input_status[4] == 1'b0) && !TX_DISABLE;
  assign TX_VALID = st_out_v && flagged;
  assign TX_DATA  = st_out_d[7:0];

  ulms_fifo #(.W(9), .DEPTH(`ULMS_STAGE_DEPTH), .CW(SW)) u_stage (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .in_valid  (st_in_v),
    .in_ready  (st_in_r),
    .in_data   (st_in_d),
    .out_valid (st_out_v),
    .out_ready (TX_READY && flagged),
    .out_data  (st_out_d),
    .limit     (SW'(`ULMS_STAGE_DEPTH)),
    .count     ()
  );

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      imm_sent_q <= 1'b0;
    else if (TX_VALID && TX_READY && st_out_d[8])
      imm_sent_q <= 1'b1;
    else if (!TX_BUSY && !st_out_v)
      imm_sent_q <= 1'b0;
  end

  assign tx_nempty = fifo_out_v || st_out_v || TX_BUSY;
  assign RTS_N = RS485_EN ? (tx_nempty == ems_q[`ULMS_EMS_INV])
                          : !MODEM_CTRL[1];

  // --------------------------------------------------------------------
  // Status words and interrupt requests.
  // --------------------------------------------------------------------
  always_comb
  begin
    line_status = 8'h00;
    line_status[`ULMS_LSR_DR]   = rx_nempty;
    line_status[`ULMS_LSR_OE]   = oe_q;
    line_status[`ULMS_LSR_PE]   = rx_nempty && rx_head[8];
    line_status[`ULMS_LSR_FE]   = rx_nempty && rx_head[9];
    line_status[`ULMS_LSR_BI]   = rx_nempty && rx_head[10];
    line_status[`ULMS_LSR_THRE] = !fifo_out_v;
    line_status[`ULMS_LSR_TEMT] = !tx_nempty;
    line_status[`ULMS_LSR_FERR] = err_cnt_q != '0;
  end

  assign LSR_INT = LSR_INT_EN && (oe_q || (ems_q[`ULMS_EMS_LSRIMM] ?
                   lsr_imm_q : |line_status[4:2]));

  // Modem status levels, taken from control bits in loopback.
  always_comb
  begin
    st = {!CD_N, !RI_N, !DSR_N, !CTS_N};
    if (MODEM_CTRL[4])
      st = {MODEM_CTRL[3], MODEM_CTRL[2], MODEM_CTRL[0],
            MODEM_CTRL[1]};
  end

  assign modem_input_status = {st, dlt_q};

  // A change landing in the read cycle is kept for the next read.
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      dlt_q     <= 4'h0;
      st_prev_q <= 4'h0;
    end
    else
    begin
      st_prev_q <= st;
      for (int i = 0; i < 4; i++)
      begin
        if (i == 2 ? (st_prev_q[2] && !st[2]) : st_prev_q[i] != st[i])
          dlt_q[i] <= 1'b1;
        else if (rd_start && A == `ULMS_OFF_MSR)
          dlt_q[i] <= 1'b0;
      end
    end
  end

  assign MSR_INT = MSR_INT_EN && |dlt_q;

  // --------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_tagged_out;
    TX_VALID && TX_READY && st_out_d[8] && !st_in_v;
  endsequence
  sequence s_drained;
    !TX_BUSY && !st_out_v;
  endsequence

  a_overrun_flag: assert property (rx_take && !rx_in_rdy |=> oe_q)
    else $error("overrun not flagged");
  a_overrun_keep: assert property (rx_take && !rx_in_rdy && !rx_pop
    |=> $stable(rx_cnt))
    else $error("overrun changed FIFO");
  a_parity_head: assert property (rx_push && RX_PE && !rx_nempty
    && !rx_pop |=> line_status[`ULMS_LSR_PE])
    else $error("parity tag missing");
  a_frame_head: assert property (rx_push && RX_FE && !rx_nempty
    && !rx_pop |=> line_status[`ULMS_LSR_FE])
    else $error("framing tag missing");
  a_break_once: assert property (rx_push && RX_BRK ##1 !RX_LINE
    ##1 (RX_VALID && RX_BRK && !RX_LINE) |-> !rx_push)
    else $error("second break loaded");
  a_thre_write: assert property (tx_push && tx_in_rdy
    |=> !line_status[`ULMS_LSR_THRE])
    else $error("holding empty after write");
  a_temt_thre: assert property (line_status[`ULMS_LSR_TEMT]
    |-> line_status[`ULMS_LSR_THRE] && !TX_VALID)
    else $error("idle while holding data");
  a_ferr_set: assert property (rx_push && rx_err_in && !rx_pop
    |=> line_status[`ULMS_LSR_FERR] [*2] or rx_pop)
    else $error("FIFO error flag missing");
  a_ri_fall: assert property (!MODEM_CTRL[4] && $fell(RI_N)
    && dlt_q[2] == 1'b0 && !$past(MODEM_CTRL[4]) |=> !dlt_q[2])
    else $error("ring delta on falling ring");
  a_msr_int: assert property ($rose(dlt_q[0]) && MSR_INT_EN
    |-> MSR_INT)
    else $error("modem interrupt missing");
  a_cts_halt: assert property (AUTO_CTS_EN && CTS_N && !MODEM_CTRL[4]
    |-> !TX_VALID)
    else $error("sent while CTS high");
  a_imm_clear: assert property (s_tagged_out ##[1:8] s_drained
    |=> !ems_q[`ULMS_EMS_IMM] || $past(wr_start))
    else $error("immediate bit stuck");
endmodule : ulms_status

// ===== ulms_params.svh
// Register offsets, field positions and reset values of the status block.
`ifndef ULMS_PARAMS_SVH
`define ULMS_PARAMS_SVH
`define ULMS_OFF_DATA     3'h0
`define ULMS_OFF_LSR      3'h5
`define ULMS_OFF_MSR      3'h6
`define ULMS_OFF_SPR      3'h7
`define ULMS_LSR_DR       0
`define ULMS_LSR_OE       1
`define ULMS_LSR_PE       2
`define ULMS_LSR_FE       3
`define ULMS_LSR_BI       4
`define ULMS_LSR_THRE     5
`define ULMS_LSR_TEMT     6
`define ULMS_LSR_FERR     7
`define ULMS_XFC_TXDIS    4
`define ULMS_XFC_RXDIS    5
`define ULMS_XFC_NINE     6
`define ULMS_XFC_FIR      7
`define ULMS_EMS_IMM      2
`define ULMS_EMS_INV      3
`define ULMS_EMS_LSRIMM   6
`define ULMS_SPR_RESET    8'hFF
`define ULMS_EMS_RESET    8'h00
`define ULMS_XFC_RESET    4'h0
`define ULMS_FIFO_DEPTH   32
`define ULMS_STAGE_DEPTH  2
`endif

// ===== ulms_pkg.sv
// Types shared by the line and modem status block.
package ulms_pkg;
  typedef logic [7:0] ulms_byte_t;
  typedef enum logic [0:0] {
    ULMS_SEL_RX = 1'b0,
    ULMS_SEL_TX = 1'b1
  } ulms_sel_e;
endpackage : ulms_pkg

// ===== ulms_far_end.sv
// Behavioural model of the serial line and modem seen by the status block.
`timescale 1ns/1ps

module ulms_far_end
  import ulms_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Transmit side
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            tx_busy,
  input  wire logic       stall,
  // Receive side
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       rx_pe,
  output logic       rx_fe,
  output logic       rx_brk,
  output logic       rx_line,
  // Modem pins
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic cd_n
);
  ulms_byte_t got_q[$];
  logic [1:0] busy_q;

  initial
  begin
    {rx_valid, rx_pe, rx_fe, rx_brk} = 4'h0;
    rx_data = 8'h00;
    rx_line = 1'b1;
    {cts_n, dsr_n, ri_n, cd_n} = 4'hF;
  end

  // A slow shifter: each character keeps it busy for three cycles.
  assign tx_ready = !stall && (busy_q == 2'h0);
  assign tx_busy  = (busy_q != 2'h0);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_q <= 2'h0;
    else if (tx_valid && tx_ready)
    begin
      got_q.push_back(tx_data);
      busy_q <= 2'h3;
    end
    else if (busy_q != 2'h0)
      busy_q <= busy_q - 2'h1;
  end

  task automatic send_rx(input logic [7:0] d, input logic [2:0] tags);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data  <= d;
    {rx_brk, rx_fe, rx_pe} <= tags;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~d;
    {rx_brk, rx_fe, rx_pe} <= ~tags;
  endtask : send_rx

  task automatic set_modem(input logic [3:0] v);
    @(posedge clk);
    {cts_n, dsr_n, ri_n, cd_n} <= v;
  endtask : set_modem
endmodule : ulms_far_end

// ===== ulms_status_tb.sv
// Self-checking testbench of the line and modem status block.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("BAD %s exp %0h got %0h", nm, e, g); \
    end \
  end

module ulms_status_tb
  import ulms_pkg::*;
;
  logic       SYS_CLK = 1'b0;
  logic       RST_N   = 1'b0;
  logic [2:0] A       = 3'h0;
  logic       CS_N    = 1'b1;
  logic       IOR_N   = 1'b1;
  logic       IOW_N   = 1'b1;
  logic [7:0] D_IN    = 8'h00;
  logic [7:0] MODEM_CTRL = 8'h00;
  logic       ENH_EN = 1'b0, AUTO_CTS_EN = 1'b0, SWAP_EN = 1'b0;
  logic       RS485_EN = 1'b0, LSR_INT_EN = 1'b0, MSR_INT_EN = 1'b0;
  logic       stall = 1'b0;
  logic       DIV_SEL = 1'b0, FIFO_EN = 1'b1;
  logic [7:0] D_OUT, TX_DATA, RX_DATA;
  logic       D_OE_N, TX_VALID, TX_READY, TX_BUSY, RTS_N;
  logic       RX_VALID, RX_PE, RX_FE, RX_BRK, RX_LINE;
  logic       CTS_N, DSR_N, RI_N, CD_N;
  logic       TX_DISABLE, RX_DISABLE, NINE_BIT, FAST_IR, LSR_INT, MSR_INT;
  int         bad_count = 0;
  int         n_compared = 0;
  int         cyc = 0;
  logic [7:0] d;

  initial
  begin
    forever #4 SYS_CLK = ~SYS_CLK;
  end

  // A small receive FIFO keeps the overrun case short.
  ulms_status #(.DEPTH(4)) i_dut (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .A(A), .CS_N(CS_N), .IOR_N(IOR_N),
    .IOW_N(IOW_N), .D_IN(D_IN), .D_OUT(D_OUT), .D_OE_N(D_OE_N),
    .DIV_SEL(DIV_SEL), .FIFO_EN(FIFO_EN), .MODEM_CTRL(MODEM_CTRL),
    .ENH_EN(ENH_EN), .AUTO_CTS_EN(AUTO_CTS_EN), .SWAP_EN(SWAP_EN),
    .RS485_EN(RS485_EN), .LSR_INT_EN(LSR_INT_EN), .MSR_INT_EN(MSR_INT_EN),
    .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_PE(RX_PE), .RX_FE(RX_FE),
    .RX_BRK(RX_BRK), .RX_LINE(RX_LINE), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .TX_DATA(TX_DATA), .TX_BUSY(TX_BUSY),
    .CTS_N(CTS_N), .DSR_N(DSR_N), .RI_N(RI_N), .CD_N(CD_N), .RTS_N(RTS_N),
    .TX_DISABLE(TX_DISABLE), .RX_DISABLE(RX_DISABLE), .NINE_BIT(NINE_BIT),
    .FAST_IR(FAST_IR), .LSR_INT(LSR_INT), .MSR_INT(MSR_INT));

  ulms_far_end i_far (
    .clk(SYS_CLK), .rst_n(RST_N), .tx_valid(TX_VALID), .tx_data(TX_DATA),
    .tx_ready(TX_READY), .tx_busy(TX_BUSY), .stall(stall),
    .rx_valid(RX_VALID), .rx_data(RX_DATA), .rx_pe(RX_PE), .rx_fe(RX_FE),
    .rx_brk(RX_BRK), .rx_line(RX_LINE), .cts_n(CTS_N), .dsr_n(DSR_N),
    .ri_n(RI_N), .cd_n(CD_N));

  task automatic wt(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : wt

  // ----------------------------------------------------------------------
  // Host bus cycles: strobe held until sampled, then one idle cycle.
  // ----------------------------------------------------------------------
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge SYS_CLK);
    {A, CS_N, IOR_N} <= {a, 2'b00};
    wt(2);
    #1 v = D_OUT;
    `CHK("bus drive", 1'b0, D_OE_N)
    @(posedge SYS_CLK);
    {CS_N, IOR_N} <= 2'b11;
    @(posedge SYS_CLK);
  endtask : rd

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge SYS_CLK);
    {A, CS_N, IOW_N, D_IN} <= {a, 2'b00, v};
    @(posedge SYS_CLK);
    {CS_N, IOW_N} <= 2'b11;
    @(posedge SYS_CLK);
  endtask : wr

  task automatic chk_rd(input string nm, input logic [2:0] a,
                        input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(nm, e, v)
  endtask : chk_rd

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic t_scratch_mode;
    chk_rd("spr reset", 3'h7, 8'hFF);
    chk_rd("lsr reset", 3'h5, 8'h60);
    wr(3'h7, 8'hA5);
    SWAP_EN <= 1'b1;
    i_far.send_rx(8'h11, 3'h0);
    wr(3'h7, 8'h03);
    chk_rd("alt rx", 3'h7, 8'h01);
    chk_rd("alt tx", 3'h7, 8'h00);
    chk_rd("alt rx2", 3'h7, 8'h01);
    wr(3'h7, 8'h01);
    chk_rd("tx level", 3'h7, 8'h00);
    RS485_EN <= 1'b1;
    wt(2);
    `CHK("rts rx", 1'b1, RTS_N)
    wr(3'h7, 8'h08);
    `CHK("rts rx inv", 1'b0, RTS_N)
    wr(3'h7, 8'h00);
    {SWAP_EN, RS485_EN} <= 2'b00;
    chk_rd("spr kept", 3'h7, 8'hA5);
    DIV_SEL <= 1'b1;
    chk_rd("div data", 3'h0, 8'h00);
    DIV_SEL <= 1'b0;
    chk_rd("pop", 3'h0, 8'h11);
  endtask : t_scratch_mode

  task automatic t_errors;
    LSR_INT_EN <= 1'b1;
    i_far.send_rx(8'h55, 3'h1);
    i_far.send_rx(8'hAA, 3'h0);
    wt(2);
    `CHK("lsr int", 1'b1, LSR_INT)
    chk_rd("lsr pe", 3'h5, 8'hE5);
    chk_rd("rx pe", 3'h0, 8'h55);
    chk_rd("lsr clean", 3'h5, 8'h61);
    `CHK("lsr int off", 1'b0, LSR_INT)
    chk_rd("rx ok", 3'h0, 8'hAA);
    i_far.send_rx(8'h66, 3'h2);
    chk_rd("lsr fe", 3'h5, 8'hE9);
    chk_rd("rx fe", 3'h0, 8'h66);
    i_far.rx_line <= 1'b0;
    i_far.send_rx(8'h00, 3'h4);
    i_far.send_rx(8'h00, 3'h4);
    chk_rd("lsr bi", 3'h5, 8'hF1);
    chk_rd("rx bi", 3'h0, 8'h00);
    chk_rd("one break", 3'h5, 8'h60);
    i_far.rx_line <= 1'b1;
    SWAP_EN <= 1'b1;
    wr(3'h7, 8'h40);
    i_far.send_rx(8'h31, 3'h0);
    i_far.send_rx(8'h32, 3'h1);
    wt(2);
    `CHK("lsr int imm", 1'b1, LSR_INT)
    chk_rd("lsr imm", 3'h5, 8'hE1);
    `CHK("lsr int imm off", 1'b0, LSR_INT)
    chk_rd("rx clean", 3'h0, 8'h31);
    chk_rd("rx tagged", 3'h0, 8'h32);
    wr(3'h7, 8'h00);
    SWAP_EN <= 1'b0;
    LSR_INT_EN <= 1'b0;
  endtask : t_errors

  task automatic t_overrun;
    for (int i = 1; i <= 5; i++)
      i_far.send_rx(8'(i), 3'h0);
    chk_rd("lsr oe", 3'h5, 8'h63);
    for (int i = 1; i <= 4; i++)
      chk_rd("fifo kept", 3'h0, 8'(i));
    chk_rd("oe cleared", 3'h5, 8'h60);
    FIFO_EN <= 1'b0;
    i_far.send_rx(8'h21, 3'h0);
    i_far.send_rx(8'h22, 3'h0);
    chk_rd("one deep oe", 3'h5, 8'h63);
    chk_rd("one deep kept", 3'h0, 8'h21);
    FIFO_EN <= 1'b1;
  endtask : t_overrun

  task automatic t_modem;
    MSR_INT_EN <= 1'b1;
    rd(3'h6, d);
    i_far.set_modem(4'h0);
    wt(4);
    `CHK("msr int", 1'b1, MSR_INT)
    chk_rd("msr deltas", 3'h6, 8'hFB);
    chk_rd("msr cleared", 3'h6, 8'hF0);
    i_far.set_modem(4'h2);
    wt(4);
    chk_rd("ring end", 3'h6, 8'hB4);
    MODEM_CTRL <= 8'h1F;
    wt(4);
    rd(3'h6, d);
    `CHK("loop all", 4'hF, d[7:4])
    MODEM_CTRL <= 8'h12;
    wt(4);
    rd(3'h6, d);
    `CHK("loop rts", 4'h1, d[7:4])
    MODEM_CTRL <= 8'h00;
    wt(4);
    rd(3'h6, d);
    `CHK("pins back", 4'hB, d[7:4])
    MSR_INT_EN <= 1'b0;
  endtask : t_modem

  task automatic t_extra;
    wr(3'h6, 8'hF0);
    `CHK("gated", 4'h0, {FAST_IR, NINE_BIT, RX_DISABLE, TX_DISABLE})
    ENH_EN <= 1'b1;
    wr(3'h6, 8'hF0);
    `CHK("all on", 4'hF, {FAST_IR, NINE_BIT, RX_DISABLE, TX_DISABLE})
    wr(3'h6, 8'h5F);
    `CHK("mixed", 4'h5, {FAST_IR, NINE_BIT, RX_DISABLE, TX_DISABLE})
    wr(3'h6, 8'h8F);
    `CHK("fast ir", 4'h8, {FAST_IR, NINE_BIT, RX_DISABLE, TX_DISABLE})
    wr(3'h6, 8'h00);
  endtask : t_extra

  task automatic t_transmit;
    int i;
    {stall, RS485_EN} <= 2'b11;
    i_far.set_modem(4'hF);
    AUTO_CTS_EN <= 1'b1;
    for (i = 0; i < 3; i++)
      wr(3'h0, 8'h3C + 8'(i));
    chk_rd("lsr busy", 3'h5, 8'h00);
    `CHK("rts tx", 1'b0, RTS_N)
    {stall, RS485_EN} <= 2'b00;
    wt(10);
    `CHK("cts halt", 1'b0, TX_VALID)
    `CHK("none sent", 0, i_far.got_q.size())
    i_far.set_modem(4'h7);
    for (i = 0; i < 100 && i_far.got_q.size() < 3; i++)
      wt(1);
    `CHK("sent all", 3, i_far.got_q.size())
    for (i = 0; i < i_far.got_q.size(); i++)
      `CHK("tx byte", 8'h3C + 8'(i), i_far.got_q[i])
    wt(10);
    chk_rd("lsr idle", 3'h5, 8'h60);
    SWAP_EN <= 1'b1;
    wr(3'h7, 8'h05);
    wr(3'h0, 8'h71);
    wt(10);
    `CHK("imm sent", 8'h71, i_far.got_q[3])
    stall <= 1'b1;
    for (i = 0; i < 3; i++)
      wr(3'h0, 8'h72);
    chk_rd("imm cleared", 3'h7, 8'h01);
    {stall, SWAP_EN, AUTO_CTS_EN} <= 3'b000;
    wt(20);
    `CHK("sent count", 7, i_far.got_q.size())
  endtask : t_transmit

  // ----------------------------------------------------------------------
  // Closing report and hang guard.
  // ----------------------------------------------------------------------
  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  always @(posedge SYS_CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end

  initial
  begin
    wt(4);
    RST_N <= 1'b1;
    t_scratch_mode();
    t_errors();
    t_overrun();
    t_modem();
    t_extra();
    t_transmit();
    end_sim();
  end
endmodule : ulms_status_tb
